// file: verilog/gpio_ports.v
`timescale 1ns/1ps
`include "gpio_ports_defines.vh"

module gpio_ports (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	// Second port pins
	input wire [7:0] port2_pin_in,
	output wire [7:0] port2_pin_out,
	output wire [7:0] port2_pin_oe,
	// Third port pins (open drain)
	input wire [7:0] port3_pin_in,
	output wire [7:0] port3_pin_out,
	output wire [7:0] port3_pin_oe,
	// Fourth port pins
	input wire [7:0] port4_pin_in,
	output wire [7:0] port4_pin_out,
	output wire [7:0] port4_pin_oe
);

	// ----------------------------------------
	// Register select positions
	// ----------------------------------------
	// One bit of the select vector per mapped register
	localparam SEL_PORT4_DIRECTION = 0;
	localparam SEL_PORT4_OUTPUT_VALUE = 1;
	localparam SEL_PORT3_DIRECTION = 2;
	localparam SEL_PORT3_OUTPUT_VALUE = 3;
	localparam SEL_PORT3_PIN_LEVEL = 4;
	localparam SEL_PORT2_DRIVER_TYPE = 5;
	localparam SEL_PORT2_DIRECTION = 6;
	localparam SEL_PORT2_OUTPUT_VALUE = 7;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	// Second port registers and their next values
	reg [7:0] port2_direction_q;
	reg [7:0] port2_direction_d;
	reg [7:0] port2_output_value_q;
	reg [7:0] port2_output_value_d;
	reg [7:0] port2_driver_type_q;
	reg [7:0] port2_driver_type_d;

	// Third port registers and their next values
	reg [7:0] port3_direction_q;
	reg [7:0] port3_direction_d;
	reg [7:0] port3_output_value_q;
	reg [7:0] port3_output_value_d;

	// Fourth port registers and their next values
	reg [7:0] port4_direction_q;
	reg [7:0] port4_direction_d;
	reg [7:0] port4_output_value_q;
	reg [7:0] port4_output_value_d;
	// Two-stage pin level synchroniser
	reg [7:0] port3_sync1_q;
	reg [7:0] port3_level_q;
	// Bus slave state
	reg [7:0] wr_sel_q;
	reg [7:0] wr_sel_d;
	reg [31:0] hrdata_q;
	reg [31:0] hrdata_d;
	reg [7:0] rd_byte;
	// Address phase decode
	wire [7:0] acc_idx;
	wire [7:0] acc_sel;
	wire [7:0] wr_byte;
	wire addr_phase;
	wire rd_phase;
	wire wr_phase;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Word index of the byte address
	function [7:0] word_index;
		input [31:0] addr;
		begin
			word_index = addr[9:2];
		end
	endfunction

	// One-hot select of the register at an index, zero if unmapped
	function [7:0] reg_select;
		input [7:0] idx;
		begin
			reg_select = 8'h00;
			if (idx == `IDX_PORT4_DIRECTION) begin
				reg_select[SEL_PORT4_DIRECTION] = 1'b1;
			end else if (idx == `IDX_PORT4_OUTPUT_VALUE) begin
				reg_select[SEL_PORT4_OUTPUT_VALUE] = 1'b1;
			end else if (idx == `IDX_PORT3_DIRECTION) begin
				reg_select[SEL_PORT3_DIRECTION] = 1'b1;
			end else if (idx == `IDX_PORT3_OUTPUT_VALUE) begin
				reg_select[SEL_PORT3_OUTPUT_VALUE] = 1'b1;
			end else if (idx == `IDX_PORT3_PIN_LEVEL) begin
				reg_select[SEL_PORT3_PIN_LEVEL] = 1'b1;
			end else if (idx == `IDX_PORT2_DRIVER_TYPE) begin
				reg_select[SEL_PORT2_DRIVER_TYPE] = 1'b1;
			end else if (idx == `IDX_PORT2_DIRECTION) begin
				reg_select[SEL_PORT2_DIRECTION] = 1'b1;
			end else if (idx == `IDX_PORT2_OUTPUT_VALUE) begin
				reg_select[SEL_PORT2_OUTPUT_VALUE] = 1'b1;
			end
		end
	endfunction

	// [RULE8] drop status select
	function [7:0] writable;
		input [7:0] sel;
		begin
			writable = sel;
			writable[SEL_PORT3_PIN_LEVEL] = 1'b0;
		end
	endfunction

	// Next value of a byte register: new data on its strobe, else held
	function [7:0] next_byte;
		input [7:0] cur;
		input strobe;
		input [7:0] data;
		begin
			if (strobe) begin
				next_byte = data;
			end else begin
				next_byte = cur;
			end
		end
	endfunction

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	// Transfer qualification in the address phase
	// Bit 1 of htrans is set for both NONSEQ and SEQ
	assign addr_phase = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
	assign rd_phase = addr_phase & ~hwrite;
	assign wr_phase = addr_phase & hwrite;
	assign acc_idx = word_index(haddr);
	assign acc_sel = reg_select(acc_idx);

	// Only the low byte of the write data is kept
	assign wr_byte = hwdata[7:0];

	// Zero wait states and always OKAY, so no transfer is ever stalled
	assign hreadyout = 1'b1;
	assign hresp = `HRESP_OKAY;
	assign hrdata = hrdata_q;

	// [RULE8] pending write select
	always @* begin
		wr_sel_d = 8'h00;
		if (wr_phase) begin
			wr_sel_d = writable(acc_sel);
		end
	end

	// [RULE5] [RULE6] [RULE7] read byte select
	// Next values are read, so a write still in its data phase is seen
	always @* begin
		// Unmapped indexes read zero
		rd_byte = 8'h00;
		if (acc_sel[SEL_PORT4_DIRECTION]) begin
			rd_byte = port4_direction_d;
		end else if (acc_sel[SEL_PORT4_OUTPUT_VALUE]) begin
			rd_byte = port4_output_value_d;
		end else if (acc_sel[SEL_PORT3_DIRECTION]) begin
			rd_byte = port3_direction_d;
		end else if (acc_sel[SEL_PORT3_OUTPUT_VALUE]) begin
			rd_byte = port3_output_value_d;
		end else if (acc_sel[SEL_PORT3_PIN_LEVEL]) begin
			rd_byte = port3_level_q;
		end else if (acc_sel[SEL_PORT2_DRIVER_TYPE]) begin
			rd_byte = port2_driver_type_d;
		end else if (acc_sel[SEL_PORT2_DIRECTION]) begin
			rd_byte = port2_direction_d;
		end else if (acc_sel[SEL_PORT2_OUTPUT_VALUE]) begin
			rd_byte = port2_output_value_d;
		end
	end

	// Read data is loaded in the address phase and stands until the next read
	always @* begin
		hrdata_d = hrdata_q;
		if (rd_phase) begin
			hrdata_d = {24'h000000, rd_byte};
		end
	end

	// Bus slave registers; nothing pending out of reset
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_sel_q <= 8'h00;
			hrdata_q <= 32'h00000000;
		end else begin
			wr_sel_q <= wr_sel_d;
			hrdata_q <= hrdata_d;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// [RULE6] [RULE7] per-register write strobes
	// Each register is loaded every edge and holds unless its strobe is set
	always @* begin
		port4_direction_d = next_byte(port4_direction_q,
			wr_sel_q[SEL_PORT4_DIRECTION], wr_byte);
		port4_output_value_d = next_byte(port4_output_value_q,
			wr_sel_q[SEL_PORT4_OUTPUT_VALUE], wr_byte);
		port3_direction_d = next_byte(port3_direction_q,
			wr_sel_q[SEL_PORT3_DIRECTION], wr_byte);
		port3_output_value_d = next_byte(port3_output_value_q,
			wr_sel_q[SEL_PORT3_OUTPUT_VALUE], wr_byte);
		port2_driver_type_d = next_byte(port2_driver_type_q,
			wr_sel_q[SEL_PORT2_DRIVER_TYPE], wr_byte);
		port2_direction_d = next_byte(port2_direction_q,
			wr_sel_q[SEL_PORT2_DIRECTION], wr_byte);
		port2_output_value_d = next_byte(port2_output_value_q,
			wr_sel_q[SEL_PORT2_OUTPUT_VALUE], wr_byte);
	end

	// [RULE4] drive type resets open drain
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port2_direction_q <= `RST_DIRECTION;
			port2_output_value_q <= `RST_OUTPUT_VALUE;
			port2_driver_type_q <= `RST_DRIVER_TYPE;
		end else begin
			port2_direction_q <= port2_direction_d;
			port2_output_value_q <= port2_output_value_d;
			port2_driver_type_q <= port2_driver_type_d;
		end
	end

	// [RULE1] [RULE2] [RULE7] third port registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port3_direction_q <= `RST_DIRECTION;
			port3_output_value_q <= `RST_OUTPUT_VALUE;
		end else begin
			port3_direction_q <= port3_direction_d;
			port3_output_value_q <= port3_output_value_d;
		end
	end

	// [RULE1] [RULE2] [RULE6] fourth port registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port4_direction_q <= `RST_DIRECTION;
			port4_output_value_q <= `RST_OUTPUT_VALUE;
		end else begin
			port4_direction_q <= port4_direction_d;
			port4_output_value_q <= port4_output_value_d;
		end
	end

	// ----------------------------------------
	// Pin level synchroniser
	// ----------------------------------------
	// [RULE8] two-stage synchroniser
	// Only the second stage feeds the read path
	// Both stages clear on reset, so early reads may show zero
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port3_sync1_q <= 8'h00;
			port3_level_q <= 8'h00;
		end else begin
			port3_sync1_q <= port3_pin_in;
			port3_level_q <= port3_sync1_q;
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// [RULE4] open drain pulls low
	// A push-pull pin in output mode is enabled for both levels
	assign port2_pin_out = port2_output_value_q;
	assign port2_pin_oe = port2_direction_q &
		(port2_driver_type_q | ~port2_output_value_q);

	// [RULE3] third port pulls low only
	// The output level is held low; the enable alone releases the line
	assign port3_pin_out = 8'h00;
	assign port3_pin_oe = port3_direction_q & ~port3_output_value_q;

	// [RULE1] [RULE2] fourth port push-pull
	// Pins in input mode are never enabled
	assign port4_pin_out = port4_output_value_q;
	assign port4_pin_oe = port4_direction_q;

endmodule

// file: verilog/gpio_ports_defines.vh
// How it works
// [RULE1] Direction bit: 0 input, 1 output; resets 0
// [RULE2] Output pins drive output-data bit; data resets 1
// [RULE3] Third-port outputs are always open drain
// [RULE4] Second-port drive type: 0 open drain, 1 push-pull
// [RULE5] Third-port status reads live pin levels
// [RULE6] Fourth port: direction then data, bit n pin n
// [RULE7] Third port: direction, data, status at consecutive indexes
// [RULE8] Status writes ignored; pin levels doubly synchronised
`ifndef GPIO_PORTS_DEFINES_VH
`define GPIO_PORTS_DEFINES_VH

// ----------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------
`define IDX_PORT4_DIRECTION 8'hb0
`define IDX_PORT4_OUTPUT_VALUE 8'hb1
`define IDX_PORT3_DIRECTION 8'hc0
`define IDX_PORT3_OUTPUT_VALUE 8'hc1
`define IDX_PORT3_PIN_LEVEL 8'hc2
`define IDX_PORT2_DRIVER_TYPE 8'hd3
`define IDX_PORT2_DIRECTION 8'hd0
`define IDX_PORT2_OUTPUT_VALUE 8'hd1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_DIRECTION 8'h00
`define RST_OUTPUT_VALUE 8'hff
`define RST_DRIVER_TYPE 8'h00

// ----------------------------------------
// AHB encodings
// ----------------------------------------
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

// file: verif/gpio_ports_monitor.sv
`timescale 1ns/1ps
// --------------
// Port checker
// --------------
module gpio_mon(
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Bus
	input wire hsel,
	input wire hwrite,
	input wire hready,
	input wire [1:0] htrans,
	input wire [31:0] haddr,
	input wire [31:0] hwdata,
	input wire [31:0] hrdata,
	// Pins
	input wire [7:0] port2_pin_out,
	input wire [7:0] port2_pin_oe,
	input wire [7:0] port3_pin_in,
	input wire [7:0] port3_pin_out,
	input wire [7:0] port3_pin_oe,
	input wire [7:0] port4_pin_out,
	input wire [7:0] port4_pin_oe
);
	reg ph_q, wr_q;
	reg [7:0] ad_q;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Track the data phase
	always @(posedge hclk) begin
		ph_q <= hsel & hready & htrans[1];
		wr_q <= hwrite;
		ad_q <= haddr[9:2];
	end
	property p_rst4; $rose(hresetn) |-> port4_pin_oe == 8'h00 && port4_pin_out == 8'hff; endproperty
	a_rst4: assert property(p_rst4) else $error("port4 reset");
	property p_rst3; $rose(hresetn) |-> port3_pin_oe == 8'h00; endproperty
	a_rst3: assert property(p_rst3) else $error("port3 reset");
	property p_od; port3_pin_out == 8'h00; endproperty
	a_od: assert property(p_od) else $error("port3 high");
	property p_dir4; ph_q && wr_q && ad_q == 8'hb0 |=> port4_pin_oe == $past(hwdata[7:0]); endproperty
	a_dir4: assert property(p_dir4) else $error("port4 dir");
	property p_val4; ph_q && wr_q && ad_q == 8'hb1 |=> port4_pin_out == $past(hwdata[7:0]); endproperty
	a_val4: assert property(p_val4) else $error("port4 val");
	property p_dir3; ph_q && wr_q && ad_q == 8'hc0 |=> (port3_pin_oe & ~$past(hwdata[7:0])) == 8'h00;
	endproperty
	a_dir3: assert property(p_dir3) else $error("port3 dir");
	property p_lvl; ph_q && !wr_q && ad_q == 8'hc2 && port3_pin_in == $past(port3_pin_in, 3)
		|-> hrdata[7:0] == port3_pin_in; endproperty
	a_lvl: assert property(p_lvl) else $error("port3 level");
	property p_drv2; ph_q && wr_q && ad_q == 8'hd3
		|=> (port2_pin_oe & port2_pin_out & ~$past(hwdata[7:0])) == 8'h00; endproperty
	a_drv2: assert property(p_drv2) else $error("port2 drive");
	c_dir4: cover property(ph_q && wr_q && ad_q == 8'hb0);
	c_lvl: cover property(ph_q && !wr_q && ad_q == 8'hc2);
	c_drv2: cover property(ph_q && wr_q && ad_q == 8'hd3);
	c_pipe: cover property(ph_q && wr_q && hsel && htrans[1] && !hwrite);
endmodule
bind gpio_ports gpio_mon u_mon(
	.hclk(hclk),
	.hresetn(hresetn),
	.hsel(hsel),
	.hwrite(hwrite),
	.hready(hready),
	.htrans(htrans),
	.haddr(haddr),
	.hwdata(hwdata),
	.hrdata(hrdata),
	.port2_pin_out(port2_pin_out),
	.port2_pin_oe(port2_pin_oe),
	.port3_pin_in(port3_pin_in),
	.port3_pin_out(port3_pin_out),
	.port3_pin_oe(port3_pin_oe),
	.port4_pin_out(port4_pin_out),
	.port4_pin_oe(port4_pin_oe)
);

// file: verif/gpio_ports_tb.sv
`timescale 1ns/1ps
// --------------
// Bench
// --------------
module gpio_ports_tb;
	reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	reg [1:0] htrans = 2'h0;
	reg [31:0] haddr = 32'h0, hwdata = 32'h0, r;
	reg [7:0] p3in = 8'h00;
	wire [31:0] hrdata;
	wire hreadyout, hresp;
	wire [7:0] p2o, p2e, p3o, p3e, p4o, p4e;
	integer errors = 0, checks = 0;
	gpio_ports dut(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .port2_pin_in(8'h00), .port2_pin_out(p2o),
		.port2_pin_oe(p2e), .port3_pin_in(p3in), .port3_pin_out(p3o), .port3_pin_oe(p3e),
		.port4_pin_in(8'h00), .port4_pin_out(p4o), .port4_pin_oe(p4e));
	// Clock
	initial forever #12.5 hclk = ~hclk;
	task tally_and_finish; begin
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end endtask
	task chk(input [31:0] a, input [31:0] e); begin
		checks = checks + 1;
		if (a !== e) begin
			errors = errors + 1;
			$display("Error %0t %h %h", $time, a, e);
		end
	end endtask
	// One single AHB transfer, read data left in r
	task xfer(input w, input [7:0] i, input [7:0] d); begin
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, i, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	end endtask
	task rd(input [7:0] i, input [31:0] e); begin
		xfer(1'b0, i, 8'h00);
		chk(r, e);
	end endtask
	task t_reset; begin
		rd(8'hb0, 32'h0);
		rd(8'hb1, 32'hff);
		rd(8'hc0, 32'h0);
		rd(8'hc1, 32'hff);
		rd(8'hd3, 32'h0);
		chk({p4e, p3e, p3o, p4o}, 32'h000000ff);
		chk({p2e, p2o}, 32'h000000ff);
	end endtask
	// Write then read of one register in back-to-back transfers
	task t_pipeline; begin
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= 1'b1;
		haddr <= {22'h0, 8'hb1, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hwrite <= 1'b0;
		hwdata <= 32'h0000005a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		chk(hrdata, 32'h5a);
		chk(p4o, 32'h5a);
	end endtask
	// Reset in mid-run after the ports were written
	task t_rerun_reset; begin
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
	end endtask
	task t_port4; begin
		xfer(1'b1, 8'hb0, 8'ha5);
		xfer(1'b1, 8'hb1, 8'h3c);
		rd(8'hb0, 32'ha5);
		rd(8'hb1, 32'h3c);
		chk({p4e, p4o}, 16'ha53c);
	end endtask
	task t_port3; begin
		xfer(1'b1, 8'hc0, 8'hf0);
		xfer(1'b1, 8'hc1, 8'h33);
		rd(8'hc0, 32'hf0);
		chk({p3e, p3o}, 16'hc000);
		p3in <= 8'h96;
		xfer(1'b1, 8'hc2, 8'h55);
		rd(8'hc2, 32'h96);
	end endtask
	task t_port2; begin
		xfer(1'b1, 8'hd0, 8'hff);
		xfer(1'b1, 8'hd1, 8'h0f);
		xfer(1'b1, 8'hd3, 8'haa);
		rd(8'hd3, 32'haa);
		chk({p2e, p2o}, 16'hfa0f);
		rd(8'h10, 32'h0);
		chk(hresp, 32'h0);
	end endtask
	// Watchdog, tests need about 95 cycles
	initial begin
		#20000;
		errors = errors + 1;
		tally_and_finish;
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_port4;
		t_pipeline;
		t_port3;
		t_port2;
		t_rerun_reset;
		tally_and_finish;
	end
endmodule
